// [rtl/diag_readout_cfg.svh]
// Register indices, field positions and reset values of the monitor readout bank
`ifndef DIAG_READOUT_CFG_SVH
`define DIAG_READOUT_CFG_SVH

`define ADDR_W            12
`define IDX_MSB           9
`define IDX_LSB           2
`define NUM_CHANNELS      5
`define RESULT_W          12

`define CFG_IDX           8'h55
`define BIAS_HIGH_IDX     8'h58
`define BIAS_LOW_IDX      8'h59
`define CH1P_HIGH_IDX     8'h62
`define CH1P_LOW_IDX      8'h63
`define CH1N_HIGH_IDX     8'h64
`define CH1N_LOW_IDX      8'h65
`define CH2P_HIGH_IDX     8'h66
`define CH2P_LOW_IDX      8'h67
`define CH2N_HIGH_IDX     8'h68
`define CH2N_LOW_IDX      8'h69
`define STATUS_IDX        8'h7f

`define CFG_RESET         8'h00
`define FREEZE_BIT        0
`define OVERRIDE_BIT      1
`define STATUS_FROZEN_BIT 7

`define CHAN_BIAS         3'h0
`define CHAN_CH1P         3'h1
`define CHAN_CH1N         3'h2
`define CHAN_CH2P         3'h3
`define CHAN_CH2N         3'h4

`define ID_BIAS           4'h1
`define ID_CH1P           4'h6
`define ID_CH1N           4'h7
`define ID_CH2P           4'h8
`define ID_CH2N           4'h9

`endif

// [rtl/diag_readout_pkg.sv]
// Types shared by the monitor readout bank and its result holder
package diag_readout_pkg;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b01,
      ST_ANSWER = 2'b10
   } bus_state_type;

   typedef struct packed {
      logic       hit;
      logic       is_cfg;
      logic       is_status;
      logic       is_result;
      logic       is_low;
      logic [2:0] chan;
   } decode_type;

   typedef struct packed {
      bus_state_type state;
      logic          freeze;
      logic          override;
      logic [4:0]    fresh;
      logic          pready;
      logic          pslverr;
      logic [31:0]   prdata;
   } bank_state_type;

   typedef struct packed {
      logic [11:0] result;
      logic        updated;
   } holder_state_type;

endpackage

// [rtl/diag_result_holder.sv]
// One channel's monitor result, updated from the converter unless frozen
`timescale 1ns/100ps
`default_nettype none
`include "diag_readout_cfg.svh"

module diag_result_holder
   import diag_readout_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   resetn,
   input  wire logic                   freeze,
   input  wire logic                   result_valid,
   input  wire logic [`RESULT_W-1:0]   result_data,
   output logic      [7:0]             high_byte,
   output logic      [3:0]             low_nibble,
   output logic                        updated
);

   holder_state_type cur_r;
   holder_state_type cur_nxt;

   always_comb begin
      cur_nxt         = cur_r;
      cur_nxt.updated = 1'b0;
      // One 12-bit store feeds both halves, so they never mix conversions
      if (result_valid && !freeze) begin
         cur_nxt.result  = result_data;
         cur_nxt.updated = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cur_r <= '0;
      end else begin
         cur_r <= cur_nxt;
      end
   end

   assign high_byte  = cur_r.result[`RESULT_W-1:`RESULT_W-8];
   assign low_nibble = cur_r.result[3:0];
   assign updated    = cur_r.updated;

endmodule
`default_nettype wire

// [rtl/diag_readout_regs.sv]
// APB register bank for the diagnostic monitor results and data configuration
`timescale 1ns/100ps
`default_nettype none
`include "diag_readout_cfg.svh"

// How it works
// - With freeze clear the results follow every conversion, with freeze set they hold.
// - Config bit 1 is a read/write temperature override control that resets to 0.
// - Each channel's high register shows result bits 11-4 read-only, reset zero.
// - Each channel's low register shows result bits 3-0 in its bits 7-4, reset zero.
// - Low register bits 3-0 read a fixed channel code, 0001b for the bias supply.
// - Output one positive reads code 0110b and output one negative reads 0111b.
// - Output two positive reads code 1000b and output two negative reads 1001b.
// - Config bits 7-2 read as zero and software writes only zero there.
module diag_readout_regs
   import diag_readout_pkg::*;
(
   input  wire logic                       clk,
   input  wire logic                       resetn,
   input  wire logic [`ADDR_W-1:0]         paddr,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic [`NUM_CHANNELS-1:0]   result_valid,
   input  wire logic [`RESULT_W-1:0]       bias_result,
   input  wire logic [`RESULT_W-1:0]       ch1_pos_result,
   input  wire logic [`RESULT_W-1:0]       ch1_neg_result,
   input  wire logic [`RESULT_W-1:0]       ch2_pos_result,
   input  wire logic [`RESULT_W-1:0]       ch2_neg_result,
   output logic                            freeze_converter_result,
   output logic                            temperature_result_override
);

   bank_state_type                         cur_r;
   bank_state_type                         cur_nxt;

   logic [`NUM_CHANNELS-1:0][7:0]          high_byte;
   logic [`NUM_CHANNELS-1:0][3:0]          low_nibble;
   logic [`NUM_CHANNELS-1:0]               updated;
   logic [`NUM_CHANNELS-1:0][`RESULT_W-1:0] result_in;

   assign result_in[`CHAN_BIAS] = bias_result;
   assign result_in[`CHAN_CH1P] = ch1_pos_result;
   assign result_in[`CHAN_CH1N] = ch1_neg_result;
   assign result_in[`CHAN_CH2P] = ch2_pos_result;
   assign result_in[`CHAN_CH2N] = ch2_neg_result;

   // Freeze comes from the register, so a conversion landing on the
   // same edge as the freeze write is still taken
   for (genvar i = 0; i < `NUM_CHANNELS; i++) begin : g_chan
      diag_result_holder u_holder (
         .clk          (clk),
         .resetn       (resetn),
         .freeze       (cur_r.freeze),
         .result_valid (result_valid[i]),
         .result_data  (result_in[i]),
         .high_byte    (high_byte[i]),
         .low_nibble   (low_nibble[i]),
         .updated      (updated[i])
      );
   end

   // Fixed channel code per result slot
   function automatic logic [3:0] chan_code(
      input logic [2:0] chan
   );
      logic [3:0] code;
      code = 4'h0;
      case (chan)
         `CHAN_BIAS: begin
            code = `ID_BIAS;
         end
         `CHAN_CH1P: begin
            code = `ID_CH1P;
         end
         `CHAN_CH1N: begin
            code = `ID_CH1N;
         end
         `CHAN_CH2P: begin
            code = `ID_CH2P;
         end
         `CHAN_CH2N: begin
            code = `ID_CH2N;
         end
         default: begin
            code = 4'h0;
         end
      endcase
      return code;
   endfunction

   function automatic decode_type result_slot(
      input logic [2:0] chan,
      input logic       is_low
   );
      decode_type d;
      d           = '0;
      d.hit       = 1'b1;
      d.is_result = 1'b1;
      d.is_low    = is_low;
      d.chan      = chan;
      return d;
   endfunction

   // Word-aligned decode; byte address is four times the register index
   function automatic decode_type decode(
      input logic [`ADDR_W-1:0] addr
   );
      decode_type d;
      logic [7:0] idx;
      d   = '0;
      idx = addr[`IDX_MSB:`IDX_LSB];
      case (idx)
         `CFG_IDX: begin
            d.hit    = 1'b1;
            d.is_cfg = 1'b1;
         end
         `STATUS_IDX: begin
            d.hit       = 1'b1;
            d.is_status = 1'b1;
         end
         `BIAS_HIGH_IDX: begin
            d = result_slot(`CHAN_BIAS, 1'b0);
         end
         `BIAS_LOW_IDX: begin
            d = result_slot(`CHAN_BIAS, 1'b1);
         end
         `CH1P_HIGH_IDX: begin
            d = result_slot(`CHAN_CH1P, 1'b0);
         end
         `CH1P_LOW_IDX: begin
            d = result_slot(`CHAN_CH1P, 1'b1);
         end
         `CH1N_HIGH_IDX: begin
            d = result_slot(`CHAN_CH1N, 1'b0);
         end
         `CH1N_LOW_IDX: begin
            d = result_slot(`CHAN_CH1N, 1'b1);
         end
         `CH2P_HIGH_IDX: begin
            d = result_slot(`CHAN_CH2P, 1'b0);
         end
         `CH2P_LOW_IDX: begin
            d = result_slot(`CHAN_CH2P, 1'b1);
         end
         `CH2N_HIGH_IDX: begin
            d = result_slot(`CHAN_CH2N, 1'b0);
         end
         `CH2N_LOW_IDX: begin
            d = result_slot(`CHAN_CH2N, 1'b1);
         end
         default: begin
            d = '0;
         end
      endcase
      // Unaligned or beyond the index range is unmapped
      if (addr[`IDX_LSB-1:0] != 2'h0) begin
         d = '0;
      end
      if (addr[`ADDR_W-1:`IDX_MSB+1] != '0) begin
         d = '0;
      end
      return d;
   endfunction

   // Config byte: only the two control bits are stored
   function automatic logic [7:0] cfg_byte(
      input bank_state_type s
   );
      logic [7:0] data;
      data                = 8'h00;
      data[`FREEZE_BIT]   = s.freeze;
      data[`OVERRIDE_BIT] = s.override;
      return data;
   endfunction

   // Own status byte: fresh flags low, freeze mirrored on top
   function automatic logic [7:0] status_byte(
      input bank_state_type s
   );
      logic [7:0] data;
      data                     = {3'h0, s.fresh};
      data[`STATUS_FROZEN_BIT] = s.freeze;
      return data;
   endfunction

   // Both halves index the same holder, so they pair unless a conversion lands between the two reads with freeze clear
   function automatic logic [7:0] result_byte(
      input decode_type                    d,
      input logic [`NUM_CHANNELS-1:0][7:0] hi,
      input logic [`NUM_CHANNELS-1:0][3:0] lo
   );
      logic [7:0] data;
      if (d.is_low) begin
         data = {lo[d.chan], chan_code(d.chan)};
      end else begin
         data = hi[d.chan];
      end
      return data;
   endfunction

   // Read data of one decoded register, upper bits zero
   function automatic logic [31:0] read_word(
      input decode_type                    d,
      input bank_state_type                s,
      input logic [`NUM_CHANNELS-1:0][7:0] hi,
      input logic [`NUM_CHANNELS-1:0][3:0] lo
   );
      logic [7:0] data;
      data = 8'h00;
      if (d.is_cfg) begin
         data = cfg_byte(s);
      end else if (d.is_status) begin
         data = status_byte(s);
      end else if (d.is_result) begin
         data = result_byte(d, hi, lo);
      end
      return {24'h0, data};
   endfunction

   // Setup answer: pready rises for the access edge, error and read data fixed now
   function automatic bank_state_type setup_answer(
      input bank_state_type                s,
      input decode_type                    d,
      input logic                          is_write,
      input logic [`NUM_CHANNELS-1:0][7:0] hi,
      input logic [`NUM_CHANNELS-1:0][3:0] lo
   );
      bank_state_type n;
      n         = s;
      n.state   = ST_ANSWER;
      n.pready  = 1'b1;
      n.pslverr = !d.hit;
      n.prdata  = 32'h0;
      if (!is_write && d.hit) begin
         n.prdata = read_word(d, s, hi, lo);
      end
      return n;
   endfunction

   // Reserved bits are dropped so they keep reading zero
   function automatic bank_state_type cfg_write(
      input bank_state_type s,
      input logic [31:0]    wdata
   );
      bank_state_type n;
      n          = s;
      n.freeze   = wdata[`FREEZE_BIT];
      n.override = wdata[`OVERRIDE_BIT];
      return n;
   endfunction

   // Reading a low register retires that channel's fresh flag
   function automatic logic [`NUM_CHANNELS-1:0] read_clear(
      input decode_type d
   );
      logic [`NUM_CHANNELS-1:0] mask;
      mask = '0;
      if (d.is_result && d.is_low) begin
         mask[d.chan] = 1'b1;
      end
      return mask;
   endfunction

   // A new conversion beats the read that clears its flag
   function automatic logic [`NUM_CHANNELS-1:0] fresh_next(
      input logic [`NUM_CHANNELS-1:0] fresh,
      input logic [`NUM_CHANNELS-1:0] clr,
      input logic [`NUM_CHANNELS-1:0] upd
   );
      return (fresh & ~clr) | upd;
   endfunction

   // Bus phase as sampled at this edge
   function automatic logic bus_setup(
      input logic sel,
      input logic enable
   );
      return sel && !enable;
   endfunction

   function automatic logic bus_access(
      input logic sel,
      input logic enable
   );
      return sel && enable;
   endfunction

   // Two-edge transfer: the setup edge decodes, answers and captures read
   // data; the access edge commits a write. No wait states are inserted.
   always_comb begin
      decode_type                dec;
      logic [`NUM_CHANNELS-1:0]  fresh_clear;
      logic                      setup;
      logic                      access;
      dec         = decode(paddr);
      fresh_clear = '0;
      setup       = bus_setup(psel, penable);
      access      = bus_access(psel, penable);
      cur_nxt     = cur_r;

      case (cur_r.state)
         ST_IDLE: begin
            cur_nxt.pready  = 1'b0;
            cur_nxt.pslverr = 1'b0;
            if (setup) begin
               // Read data is sampled in the setup cycle and held
               cur_nxt = setup_answer(cur_nxt, dec, pwrite, high_byte, low_nibble);
            end
         end
         ST_ANSWER: begin
            cur_nxt.state   = ST_IDLE;
            cur_nxt.pready  = 1'b0;
            cur_nxt.pslverr = 1'b0;
            if (access && pwrite && dec.is_cfg) begin
               cur_nxt = cfg_write(cur_nxt, pwdata);
            end
            if (access && !pwrite) begin
               fresh_clear = read_clear(dec);
            end
         end
         default: begin
            cur_nxt.state   = ST_IDLE;
            cur_nxt.pready  = 1'b0;
            cur_nxt.pslverr = 1'b0;
         end
      endcase

      cur_nxt.fresh = fresh_next(cur_r.fresh, fresh_clear, updated);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cur_r          <= '0;
         cur_r.state    <= ST_IDLE;
         cur_r.freeze   <= 1'(`CFG_RESET >> `FREEZE_BIT);
         cur_r.override <= 1'(`CFG_RESET >> `OVERRIDE_BIT);
      end else begin
         cur_r <= cur_nxt;
      end
   end

   assign prdata                      = cur_r.prdata;
   assign pready                      = cur_r.pready;
   assign pslverr                     = cur_r.pslverr;
   assign freeze_converter_result     = cur_r.freeze;
   assign temperature_result_override = cur_r.override;

endmodule
`default_nettype wire

// [tb/diag_readout_regs_properties.sv]
// Concurrent properties of the monitor readout register bank
`timescale 1ns/100ps
`default_nettype none
`include "diag_readout_cfg.svh"
module diag_readout_regs_chk (
   input wire logic [`ADDR_W-1:0] paddr,
   input wire logic               clk,
   input wire logic               resetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [31:0]        pwdata,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic               freeze_converter_result,
   input wire logic               temperature_result_override
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   logic       rd;
   logic       wr;
   logic [9:0] ix;
   assign rd = psel && penable && pready && !pwrite && !pslverr;
   assign wr = psel && penable && pready && pwrite && !pslverr;
   assign ix = paddr[11:2];
   property p_frz_wr;
      wr && ix == `CFG_IDX |=> freeze_converter_result == $past(pwdata[0]);
   endproperty
   a_frz_wr: assert property (p_frz_wr) else $error("freeze write");
   property p_ovr_wr;
      wr && ix == `CFG_IDX |=> temperature_result_override == $past(pwdata[1]);
   endproperty
   a_ovr_wr: assert property (p_ovr_wr) else $error("override write");
   property p_ovr_rst;
      $rose(resetn) |-> !temperature_result_override && !freeze_converter_result;
   endproperty
   a_ovr_rst: assert property (p_ovr_rst) else $error("config reset");
   // Read data is captured at setup, so compare with outputs one cycle back
   property p_cfg_rd;
      rd && ix == `CFG_IDX |-> prdata == {30'h0, $past(temperature_result_override),
         $past(freeze_converter_result)};
   endproperty
   a_cfg_rd: assert property (p_cfg_rd) else $error("config read");
   property p_rd_pad;
      rd |-> prdata[31:8] == 24'h0;
   endproperty
   a_rd_pad: assert property (p_rd_pad) else $error("read upper bits");
   property p_id_bias;
      rd && ix == `BIAS_LOW_IDX |-> prdata[3:0] == `ID_BIAS;
   endproperty
   a_id_bias: assert property (p_id_bias) else $error("bias code");
   property p_id_ch1;
      (rd && ix == `CH1P_LOW_IDX |-> prdata[3:0] == `ID_CH1P)
         and (rd && ix == `CH1N_LOW_IDX |-> prdata[3:0] == `ID_CH1N);
   endproperty
   a_id_ch1: assert property (p_id_ch1) else $error("out one code");
   property p_id_ch2;
      (rd && ix == `CH2P_LOW_IDX |-> prdata[3:0] == `ID_CH2P)
         and (rd && ix == `CH2N_LOW_IDX |-> prdata[3:0] == `ID_CH2N);
   endproperty
   a_id_ch2: assert property (p_id_ch2) else $error("out two code");
endmodule
bind diag_readout_regs diag_readout_regs_chk u_chk (.*);
`default_nettype wire

// [tb/diag_monitor_readout_regs_tb_top.sv]
// Self-checking bench for the monitor readout register bank
`timescale 1ns/100ps
`default_nettype none
`include "diag_readout_cfg.svh"
module diag_monitor_readout_regs_tb_top;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        frz;
   logic        ovr;
   logic [4:0]  vld = 5'h0;
   logic [11:0] res [5] = '{default: '0};
   logic [11:0] cur [5] = '{default: '0};
   logic [7:0]  hix [5] = '{`BIAS_HIGH_IDX, `CH1P_HIGH_IDX, `CH1N_HIGH_IDX,
                           `CH2P_HIGH_IDX, `CH2N_HIGH_IDX};
   logic [3:0]  ids [5] = '{`ID_BIAS, `ID_CH1P, `ID_CH1N, `ID_CH2P, `ID_CH2N};
   logic [31:0] rd;
   logic        err;
   int          fail_count = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   diag_readout_regs u_dut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .result_valid(vld), .bias_result(res[0]),
      .ch1_pos_result(res[1]), .ch1_neg_result(res[2]), .ch2_pos_result(res[3]),
      .ch2_neg_result(res[4]), .freeze_converter_result(frz),
      .temperature_result_override(ovr));
   always #5 clk = ~clk;
   task end_of_test;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         end_of_test;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Idle cycle between transfers keeps each strobe to one driver per step
   task apb(input logic w, input logic [9:0] ix, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {ix, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait for pready
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rchk(input logic [9:0] ix, input logic [31:0] exp);
      apb(1'b0, ix, 32'h0);
      chk(rd, exp);
      chk({31'h0, err}, 32'h0);
   endtask
   task conv(input logic [11:0] base, input logic upd);
      @(posedge clk);
      for (int c = 0; c < 5; c++) begin
         res[c] <= base + 12'(c) * 12'h123;
         if (upd)
            cur[c] = base + 12'(c) * 12'h123;
      end
      vld <= 5'h1f;
      @(posedge clk);
      vld <= 5'h0;
   endtask
   task chan_chk;
      for (int c = 0; c < 5; c++) begin
         rchk({2'b00, hix[c]}, {24'h0, cur[c][11:4]});
         rchk({2'b00, hix[c] + 8'h01}, {24'h0, cur[c][3:0], ids[c]});
      end
   endtask
   task t_reset;
      chan_chk;
      rchk({2'b00, `CFG_IDX}, 32'h0);
      $display("test reset done");
   endtask
   task t_live;
      conv(12'h5a3, 1'b1);
      chan_chk;
      conv(12'hc3e, 1'b1);
      chan_chk;
      $display("test live done");
   endtask
   task t_freeze;
      apb(1'b1, {2'b00, `CFG_IDX}, 32'h1);
      @(negedge clk);
      chk({31'h0, frz}, 32'h1);
      rchk({2'b00, `STATUS_IDX}, 32'h80);
      rchk({2'b00, hix[0]}, {24'h0, cur[0][11:4]});
      conv(12'h9e7, 1'b0);
      rchk({2'b00, hix[0] + 8'h01}, {24'h0, cur[0][3:0], ids[0]});
      chan_chk;
      apb(1'b1, {2'b00, `CFG_IDX}, 32'h2);
      rchk({2'b00, `CFG_IDX}, 32'h2);
      chk({30'h0, ovr, frz}, 32'h2);
      conv(12'h71d, 1'b1);
      rchk({2'b00, `STATUS_IDX}, 32'h1f);
      chan_chk;
      apb(1'b1, {2'b00, `CFG_IDX}, 32'h0);
      @(negedge clk);
      chk({30'h0, ovr, frz}, 32'h0);
      $display("test freeze done");
   endtask
   task t_bad;
      apb(1'b1, {2'b00, `BIAS_HIGH_IDX}, 32'hff);
      rchk({2'b00, `BIAS_HIGH_IDX}, {24'h0, cur[0][11:4]});
      apb(1'b0, 10'h07e, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      $display("test bad address done");
   endtask
   initial begin
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      t_reset;
      t_live;
      t_freeze;
      t_bad;
      end_of_test;
   end
endmodule
`default_nettype wire
